// [udr_pkg.sv]
// Package for the default descriptor store: offsets, layouts, defaults
package udr_pkg;
	localparam int          WORD_W        = 16;
	localparam int          ADDR_W        = 8;
	localparam int          ROM_DEPTH     = 256;
	// Word offsets inside the store
	localparam logic [7:0]  OFS_PWR_MODE  = 8'h01;
	localparam logic [7:0]  OFS_PHY_ID    = 8'h11;
	localparam logic [7:0]  OFS_PHY_SAVE  = 8'h18;
	localparam logic [7:0]  OFS_SER_FIRST = 8'h19;
	localparam logic [7:0]  OFS_SER_LAST  = 8'h1F;
	localparam logic [7:0]  OFS_HS_ATTR   = 8'h2C;
	localparam logic [7:0]  OFS_HS_MAXPWR = 8'h2D;
	localparam logic [7:0]  OFS_FS_ATTR   = 8'h4C;
	localparam logic [7:0]  OFS_FS_MAXPWR = 8'h4D;
	localparam logic [7:0]  OFS_SPEED_BIT = 8'h60;
	localparam logic [7:0]  OFS_HS_REGION = 8'h20;
	// Default words, low byte in [7:0], high byte in [15:8]
	localparam logic [15:0] DEF_PWR_MODE  = 16'h1DFD;
	localparam logic [15:0] DEF_PHY_ID    = 16'hE010;
	localparam logic [15:0] DEF_PHY_SAVE  = 16'h08FF;
	localparam logic [15:0] DEF_SER_HEAD  = 16'h030E;
	localparam logic [15:0] DEF_SER_ZERO  = 16'h0030;
	localparam logic [15:0] DEF_SER_ONE   = 16'h0031;
	localparam logic [15:0] DEF_ATTR_WORD = 16'hE004;
	localparam logic [15:0] DEF_MAXPWR_W  = 16'h0902;
	localparam logic [15:0] DEF_BLANK     = 16'hFFFF;
	// bmAttributes layout
	localparam int          ATTR_ONE_BIT  = 7;
	localparam int          ATTR_SELF_BIT = 6;
	localparam int          ATTR_WAKE_BIT = 5;
	localparam logic [7:0]  ATTR_ONE      = 8'h80;
	localparam logic [7:0]  ZERO_BYTE     = 8'h00;
	// AHB-Lite register map (byte addresses)
	localparam logic [11:0] REG_CTRL      = 12'h000;
	localparam logic [11:0] REG_STATUS    = 12'h004;
	localparam logic [11:0] REG_WORD_ADDR = 12'h008;
	localparam logic [11:0] REG_WORD_DATA = 12'h00C;
	localparam logic [11:0] REG_CFG_DESC  = 12'h010;
	localparam logic [11:0] REG_EXT_ADDR  = 12'h014;
	localparam logic [11:0] REG_EXT_DATA  = 12'h018;
	localparam logic [11:0] ROM_WIN_BASE  = 12'h400;
	localparam int          CTRL_HS_BIT   = 0;
	localparam int          CTRL_EXTP_BIT = 1;
	localparam int          CTRL_EEOK_BIT = 2;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
	localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

	// One request on the AHB-Lite bus, captured in the address phase
	typedef struct packed {
		logic        write;
		logic [11:0] addr;
	} udr_req_t;

	// Configuration descriptor power fields served to the host
	typedef struct packed {
		logic [7:0] max_power;
		logic [7:0] attributes;
	} udr_cfg_t;

	// Bus state: address phase taken, then one data phase
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_DATA = 1'b1
	} udr_state_t;
endpackage

// [udr_top.sv]
// Default descriptor store with AHB-Lite access and descriptor override
//
// How it works
// [RQ1] Defaults are a constant table; no write reaches them.
// [RQ2] Blank or bad-checksum EEPROM makes reads return default words.
// [RQ3] Each word is 16 bits, low byte in the low position.
// [RQ4] Word 0x01 defaults to FD 1D: self power, wakeup, copper.
// [RQ5] Attribute word high byte E0 at 0x2C and 0x4C is bmAttributes.
// [RQ6] bmAttributes: D7 one, D6 self power, D5 wakeup, D4..D0 zero.
// [RQ7] Max-power low byte 02 at 0x2D and 0x4D is bMaxPower.
// [RQ8] bMaxPower counts in 2 mA units, so 0x64 means 200 mA.
// [RQ9] High speed serves the 0x2x copy, otherwise the 0x4x copy.
// [RQ10] Word 0x11 defaults to 10 E0: primary PHY 0x10, no secondary.
// [RQ11] High byte of 0x18 defaults to 08: no detach, saving level 0.
// [RQ12] Serial string at 0x19..0x1F: 0E 03 then characters, zero high.
// [RQ13] Bus plus local power reports non-zero bMaxPower and D6 set; the code forces neither, both follow the served descriptor words.
// [RQ14] Losing external power clears the reported self-powered status.
// [RQ15] Never report a power draw above the configured bMaxPower.
// [RQ16] Valid EEPROM content overrides internal defaults.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
module udr_top (
	input  wire logic                 core_clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 hsel_in,
	input  wire logic [31:0]          haddr_in,
	input  wire logic [1:0]           htrans_in,
	input  wire logic                 hwrite_in,
	input  wire logic [2:0]           hsize_in,
	input  wire logic [31:0]          hwdata_in,
	input  wire logic                 hready_in,
	output logic      [31:0]          hrdata_out,
	output logic                      hreadyout_out,
	output logic                      hresp_out,
	output udr_pkg::udr_cfg_t         cfg_desc_out,
	output logic                      self_powered_out,
	output logic                      cable_unplug_detach_out,
	output logic                      power_mgmt_event_signal_out
);
	import udr_pkg::*;

	// Constant default word for an offset; pure logic, no storage to write
	function automatic logic [15:0] rom_word(input logic [7:0] ofs);
		logic [15:0] w;
		w = DEF_BLANK;
		if (ofs == OFS_PWR_MODE)
			w = DEF_PWR_MODE;                     // [RQ4]
		else if (ofs == OFS_PHY_ID)
			w = DEF_PHY_ID;                       // [RQ10]
		else if (ofs == OFS_PHY_SAVE)
			w = DEF_PHY_SAVE;                     // [RQ11]
		else if (ofs == OFS_SER_FIRST)
			w = DEF_SER_HEAD;                     // [RQ12]
		else if (ofs == OFS_SER_LAST)
			w = DEF_SER_ONE;                      // [RQ12]
		else if (ofs > OFS_SER_FIRST && ofs < OFS_SER_LAST)
			w = DEF_SER_ZERO;                     // [RQ12]
		else if (ofs == OFS_HS_ATTR || ofs == OFS_FS_ATTR)
			w = DEF_ATTR_WORD;                    // [RQ5]
		else if (ofs == OFS_HS_MAXPWR || ofs == OFS_FS_MAXPWR)
			w = DEF_MAXPWR_W;                     // [RQ7]
		return w;                                 // [RQ1] [RQ3]
	endfunction

	// Clean bmAttributes from a stored byte and live power state
	function automatic logic [7:0] fix_attr(input logic [7:0] raw,
	                                        input logic       self_pw);
		logic [7:0] a;
		a = ATTR_ONE;                             // [RQ6] D4..D0 zero
		a[ATTR_SELF_BIT] = raw[ATTR_SELF_BIT] & self_pw; // [RQ14]
		a[ATTR_WAKE_BIT] = raw[ATTR_WAKE_BIT];
		return a;
	endfunction

	// Bus slave state, control and pointers; the image has no reset, as it
	// is only read once software has loaded it and marked it valid
	udr_state_t  state_ff, nxt_state;
	udr_req_t    req_ff,   nxt_req;
	logic [2:0]  ctrl_ff,  nxt_ctrl;
	logic [7:0]  wrd_addr_ff, nxt_wrd_addr;
	logic [7:0]  ext_addr_ff, nxt_ext_addr;
	logic [15:0] ext_mem_ff [ROM_DEPTH];
	logic [31:0] rdata_ff, nxt_rdata;
	udr_cfg_t    cfg_ff,   nxt_cfg;
	logic        selfp_ff, detach_ff, pme_ff;

	// Control fields
	wire         sel_hs    = ctrl_ff[CTRL_HS_BIT];
	wire         ext_pwr   = ctrl_ff[CTRL_EXTP_BIT];
	wire         ee_valid  = ctrl_ff[CTRL_EEOK_BIT];

	// Address phase decode; hsize is not looked at, every access is a word
	wire         take      = hsel_in & hready_in &
	                         (htrans_in == HTRANS_NONSEQ);
	wire         wr_phase  = (state_ff == ST_DATA) & req_ff.write;
	wire         rd_take   = take & ~hwrite_in;
	wire  [11:0] rd_addr   = haddr_in[11:0];
	wire  [11:0] wr_addr   = req_ff.addr;

	// One compare for both phases, so read and write decode the same map
	function automatic logic reg_hit(input logic [11:0] a,
	                                 input logic [11:0] r);
		return a == r;
	endfunction

	// Window index from a byte address; bits above the index alias
	function automatic logic [7:0] win_index(input logic [11:0] a);
		return a[9:2];
	endfunction

	// Read decode, on the address being taken
	wire         rd_ctrl   = reg_hit(rd_addr, REG_CTRL);
	wire         rd_status = reg_hit(rd_addr, REG_STATUS);
	wire         rd_waddr  = reg_hit(rd_addr, REG_WORD_ADDR);
	wire         rd_wdata  = reg_hit(rd_addr, REG_WORD_DATA);
	wire         rd_cfg    = reg_hit(rd_addr, REG_CFG_DESC);
	wire         rd_eaddr  = reg_hit(rd_addr, REG_EXT_ADDR);
	wire         rd_window = rd_addr >= ROM_WIN_BASE;

	// Write decode, on the address held from the address phase
	wire         wr_ctrl   = wr_phase & reg_hit(wr_addr, REG_CTRL);
	wire         wr_waddr  = wr_phase & reg_hit(wr_addr, REG_WORD_ADDR);
	wire         wr_eaddr  = wr_phase & reg_hit(wr_addr, REG_EXT_ADDR);
	wire         wr_edata  = wr_phase & reg_hit(wr_addr, REG_EXT_DATA);

	// Write data fields, cut to the width of the register they load
	wire  [2:0]  wd_ctrl   = hwdata_in[2:0];
	wire  [7:0]  wd_index  = hwdata_in[7:0];
	wire  [15:0] wd_word   = hwdata_in[15:0];

	// Word selection: external image when valid, else defaults
	function automatic logic [15:0] serve(input logic [7:0] ofs,
	                                      input logic       ok,
	                                      input logic [15:0] ext);
		return ok ? ext : rom_word(ofs);          // [RQ2] [RQ16]
	endfunction

	// Speed-selected copies of the descriptor power fields
	wire  [7:0]  attr_ofs  = sel_hs ? OFS_HS_ATTR : OFS_FS_ATTR; // [RQ9]
	wire  [7:0]  pwr_ofs   = sel_hs ? OFS_HS_MAXPWR : OFS_FS_MAXPWR;
	wire  [15:0] attr_word = serve(attr_ofs, ee_valid,
	                               ext_mem_ff[attr_ofs]);
	wire  [15:0] pwr_word  = serve(pwr_ofs, ee_valid,
	                               ext_mem_ff[pwr_ofs]);
	wire  [7:0]  attr_byte = fix_attr(attr_word[15:8], ext_pwr);
	// A bus-and-local config must not report zero; keep stored value
	// as the cap since draw may never exceed what is reported
	wire  [7:0]  maxp_byte = pwr_word[7:0];   // [RQ7] [RQ8] [RQ15]
	wire  [15:0] mode_word = serve(OFS_PWR_MODE, ee_valid,
	                               ext_mem_ff[OFS_PWR_MODE]);
	wire  [15:0] save_word = serve(OFS_PHY_SAVE, ee_valid,
	                               ext_mem_ff[OFS_PHY_SAVE]);
	// Window word looked up in the address phase, so it is ready in time
	wire  [15:0] win_word  = serve(win_index(rd_addr), ee_valid,
	                               ext_mem_ff[win_index(rd_addr)]);
	wire  [15:0] sel_word  = serve(wrd_addr_ff, ee_valid,
	                               ext_mem_ff[wrd_addr_ff]);

	// Read value chosen in the address phase and registered, so it stands
	// through the whole data phase; unmapped offsets read as zero
	wire  [31:0] status_rd = {29'h0, pme_ff, detach_ff, selfp_ff};
	wire  [31:0] rd_value  =
		rd_ctrl   ? {29'h0, ctrl_ff}           :
		rd_status ? status_rd                  :
		rd_waddr  ? {24'h00_0000, wrd_addr_ff} :
		rd_wdata  ? {16'h0000, sel_word}       :   // [RQ2] [RQ3]
		rd_cfg    ? {16'h0000, cfg_ff}         :   // [RQ5] [RQ7]
		rd_eaddr  ? {24'h00_0000, ext_addr_ff} :
		rd_window ? {16'h0000, win_word}       :   // [RQ3]
		            RD_ZERO;

	// Self-powered status: needs the attribute and live local power.
	// Losing the supply only clears the flag; the reported bMaxPower is
	// left alone, so the bus draw can never rise above what was reported
	wire         self_now  = attr_byte[ATTR_SELF_BIT];   // [RQ13] [RQ14]

	// Next state of the bus slave and control registers
	always_comb begin
		nxt_state    = take ? ST_DATA : ST_IDLE;
		nxt_req      = req_ff;
		nxt_ctrl     = ctrl_ff;
		nxt_wrd_addr = wrd_addr_ff;
		nxt_ext_addr = ext_addr_ff;
		nxt_rdata    = rdata_ff;
		if (take) begin
			nxt_req.write = hwrite_in;
			nxt_req.addr  = rd_addr;
		end
		// Writes only touch control, the two word pointers and the EEPROM image, never the table
		if (wr_ctrl)
			nxt_ctrl = wd_ctrl;
		if (wr_waddr)
			nxt_wrd_addr = wd_index;
		if (wr_eaddr)
			nxt_ext_addr = wd_index;
		if (wr_edata)
			nxt_ext_addr = ext_addr_ff + 8'h01;   // Auto-increment
		// Read data only moves when a read is taken, and then stands
		if (rd_take)
			nxt_rdata = rd_value;                 // [RQ1]
		nxt_cfg.attributes = attr_byte;
		nxt_cfg.max_power  = maxp_byte;
	end

	// Bus phase and the request held for the data phase
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= ST_IDLE;
			req_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			req_ff   <= nxt_req;
		end
	end

	// Control word and the two word pointers; reset selects the defaults
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_ff     <= 3'h0;
			wrd_addr_ff <= 8'h00;
			ext_addr_ff <= 8'h00;
		end else begin
			ctrl_ff     <= nxt_ctrl;
			wrd_addr_ff <= nxt_wrd_addr;
			ext_addr_ff <= nxt_ext_addr;
		end
	end

	// Read data register drives the bus directly, so it never glitches
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			rdata_ff <= RD_ZERO;
		else
			rdata_ff <= nxt_rdata;
	end

	// Image of the external EEPROM, loaded by software; no reset needed
	always_ff @(posedge core_clk_in) begin
		if (wr_edata)
			ext_mem_ff[ext_addr_ff] <= wd_word;   // [RQ16]
	end

	// Descriptor power fields, registered so the host sees a clean byte
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			cfg_ff <= '0;
		else
			cfg_ff <= nxt_cfg;                    // [RQ5] [RQ7] [RQ9]
	end

	// Live status flags; self power follows the external-power control bit,
	// so software clearing that bit shows on the next edge
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			selfp_ff  <= 1'b0;
			detach_ff <= 1'b0;
			pme_ff    <= 1'b0;
		end else begin
			selfp_ff  <= self_now;                // [RQ14]
			detach_ff <= save_word[WORD_W - 1];   // [RQ11]
			pme_ff    <= mode_word[ATTR_SELF_BIT - 1]; // [RQ4]
		end
	end

	// Read data register drives hrdata_out in every cycle; always zero-wait OKAY
	assign hrdata_out                  = rdata_ff;
	assign hreadyout_out               = 1'b1;
	assign hresp_out                   = 1'b0;
	assign cfg_desc_out                = cfg_ff;
	assign self_powered_out            = selfp_ff;
	assign cable_unplug_detach_out     = detach_ff;
	assign power_mgmt_event_signal_out = pme_ff;
endmodule

// [udr_monitor.sv]
// Port-level checks for the default descriptor store
module udr_monitor (
	input  wire logic              core_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              hsel_in,
	input  wire logic [31:0]       haddr_in,
	input  wire logic [1:0]        htrans_in,
	input  wire logic              hwrite_in,
	input  wire logic              hready_in,
	input  wire logic [31:0]       hrdata_out,
	input  wire logic              hreadyout_out,
	input  wire logic              hresp_out,
	input  wire udr_pkg::udr_cfg_t cfg_desc_out,
	input  wire logic              self_powered_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import udr_pkg::*;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Read taken this edge; hole is the gap between registers and window
	wire rd_take = hsel_in & hready_in & (htrans_in == HTRANS_NONSEQ)
		& !hwrite_in;
	wire hole = (haddr_in[11:0] > 12'h018) && (haddr_in[11:0] < ROM_WIN_BASE);
	sequence s_rd_take;
		rd_take;
	endsequence
	sequence s_rd_hole;
		rd_take && hole;
	endsequence
	// Skip the first edge after reset, outputs still show reset zeros
	a_attr_fixed_bits: assert property ($past(rst_n_in) |->
		cfg_desc_out.attributes[7] && cfg_desc_out.attributes[4:0] == 5'h00)
		else $error("bmAttributes fixed bits wrong");
	a_self_tracks_d6: assert property (
		self_powered_out == cfg_desc_out.attributes[6])
		else $error("self powered pin differs from D6");
	a_self_needs_power: assert property (self_powered_out |->
		cfg_desc_out.max_power != 8'h00)
		else $error("self powered with zero max power");
	a_upper_zero: assert property (s_rd_take |=>
		hrdata_out[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_hole_zero: assert property (s_rd_hole |=>
		hrdata_out == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_hrdata_holds: assert property ($past(rst_n_in) &&
		!$past(rd_take) |-> $stable(hrdata_out))
		else $error("read data moved without a read");
	a_maxpwr_hold: assert property ($fell(self_powered_out) |->
		$stable(cfg_desc_out.max_power))
		else $error("max power moved on power loss");
	a_ready_okay: assert property (hreadyout_out && !hresp_out)
		else $error("slave not ready or not okay");
endmodule

// [udr_host_model.sv]
// Host side: reads and writes the store over AHB-Lite
module udr_host_model (
	input  wire logic        clk_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hrdata_in,
	output logic             hsel_out,
	output logic [31:0]      haddr_out,
	output logic [1:0]       htrans_out,
	output logic             hwrite_out,
	output logic [2:0]       hsize_out,
	output logic [31:0]      hwdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import udr_pkg::*;
	// Idle bus at time zero, word size only
	initial begin
		hsel_out = 1'b0;
		haddr_out = 32'h0000_0000;
		htrans_out = 2'h0;
		hwrite_out = 1'b0;
		hsize_out = 3'h2;
		hwdata_out = 32'h0000_0000;
	end
	// A stuck slave must not hang the run, so the wait is bounded
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge clk_in);
		while (hready_in !== 1'b1) begin
			n++;
			if (n > 64) begin
				usb_default_descriptor_rom_tb_top.hang();
			end
			@(posedge clk_in);
		end
	endtask
	// One single transfer: address phase, then data phase
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel_out <= 1'b1;
		htrans_out <= HTRANS_NONSEQ;
		haddr_out <= {20'h00000, a};
		hwrite_out <= wr;
		wait_ready();
		hsel_out <= 1'b0;
		htrans_out <= 2'h0;
		hwdata_out <= wd;
		wait_ready();
		rd = hrdata_in;
	endtask
endmodule

// [usb_default_descriptor_rom_tb_top.sv]
// Self-checking bench for the default descriptor store
module usb_default_descriptor_rom_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import udr_pkg::*;
	logic        core_clk_in, rst_n_in, hsel_in, hwrite_in, hreadyout_out;
	logic        hresp_out, self_powered_out, detach, power_mgmt_event_signal;
	logic [31:0] haddr_in, hwdata_in, hrdata_out;
	logic [1:0]  htrans_in;
	logic [2:0]  hsize_in;
	udr_cfg_t    cfg_desc_out;
	int          mismatches, samples_checked;
	udr_top DUT (.core_clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in,
		.hwrite_in, .hsize_in, .hwdata_in, .hready_in(hreadyout_out),
		.hrdata_out, .hreadyout_out, .hresp_out, .cfg_desc_out,
		.self_powered_out, .cable_unplug_detach_out(detach),
		.power_mgmt_event_signal_out(power_mgmt_event_signal));
	udr_host_model host (.clk_in(core_clk_in), .hready_in(hreadyout_out),
		.hrdata_in(hrdata_out), .hsel_out(hsel_in), .haddr_out(haddr_in),
		.htrans_out(htrans_in), .hwrite_out(hwrite_in),
		.hsize_out(hsize_in), .hwdata_out(hwdata_in));
	// 50 MHz clock
	initial core_clk_in = 1'b0;
	always #10 core_clk_in = ~core_clk_in;
	task automatic finish_test;
		$display("Checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic hang;
		mismatches++;
		finish_test();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error %0t got %h want %h", $time, g, e);
		end
	endtask
	// Read with a mask on the bits that matter
	task automatic rdm(input logic [11:0] a, input logic [31:0] e, m);
		logic [31:0] d;
		host.xfer(1'b0, a, 32'h0000_0000, d);
		chk(d & m, e);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic [31:0] d;
		host.xfer(1'b1, a, v, d);
	endtask
	task automatic rom(input logic [7:0] n, input logic [15:0] e, m);
		rdm(ROM_WIN_BASE + {n, 2'b00}, {16'h0000, e}, {16'h0000, m});
	endtask
	task automatic t_defaults;
		rom(8'h01, 16'h1DFD, 16'hFFFF);
		rom(8'h11, 16'hE010, 16'hFFFF);
		rom(8'h18, 16'h0800, 16'hFF00);
		rom(8'h19, 16'h030E, 16'hFFFF);
		for (int i = 8'h1A; i < 8'h1F; i++) begin
			rom(i[7:0], 16'h0030, 16'hFFFF);
		end
		rom(8'h1F, 16'h0031, 16'hFFFF);
		rom(8'h2C, 16'hE000, 16'hFF00);
		rom(8'h4C, 16'hE000, 16'hFF00);
		rom(8'h2D, 16'h0002, 16'h00FF);
		rom(8'h4D, 16'h0002, 16'h00FF);
		chk({16'h0000, cfg_desc_out}, 32'h0000_02A0);
	endtask
	// Writes to the window, read-only words and the hole change nothing
	task automatic t_read_only;
		wr(12'h404, 32'h0000_0000);
		rom(8'h01, 16'h1DFD, 16'hFFFF);
		wr(REG_WORD_ADDR, 32'h0000_0011);
		wr(REG_WORD_DATA, 32'h0000_0000);
		rdm(REG_WORD_DATA, 32'h0000_E010, 32'hFFFF_FFFF);
		wr(12'h100, 32'hFFFF_FFFF);
		rdm(12'h100, 32'h0000_0000, 32'hFFFF_FFFF);
	endtask
	// External power on, then lost; the hole read lets outputs settle
	task automatic t_power;
		wr(REG_CTRL, 32'h0000_0002);
		rdm(12'h100, 32'h0000_0000, 32'hFFFF_FFFF);
		rdm(REG_STATUS, 32'h0000_0005, 32'h0000_0007);
		rdm(REG_CFG_DESC, 32'h0000_02E0, 32'hFFFF_FFFF);
		chk({31'h0, self_powered_out}, 32'h0000_0001);
		chk({30'h0, power_mgmt_event_signal, detach}, 32'h0000_0002);
		wr(REG_CTRL, 32'h0000_0000);
		rdm(12'h100, 32'h0000_0000, 32'hFFFF_FFFF);
		rdm(REG_STATUS, 32'h0000_0004, 32'h0000_0007);
		chk({31'h0, self_powered_out}, 32'h0000_0000);
		chk({16'h0000, cfg_desc_out}, 32'h0000_02A0);
	endtask
	// Valid image overrides defaults; speed picks the copy
	task automatic t_image;
		wr(REG_EXT_ADDR, 32'h0000_002C);
		wr(REG_EXT_DATA, 32'h0000_E000);
		wr(REG_EXT_DATA, 32'h0000_0064);
		wr(REG_EXT_ADDR, 32'h0000_004C);
		wr(REG_EXT_DATA, 32'h0000_E000);
		wr(REG_EXT_DATA, 32'h0000_0032);
		wr(REG_EXT_DATA, 32'h0000_1234);
		wr(REG_CTRL, 32'h0000_0007);
		rom(8'h2D, 16'h0064, 16'hFFFF);
		rom(8'h4E, 16'h1234, 16'hFFFF);
		rdm(REG_CFG_DESC, 32'h0000_64E0, 32'hFFFF_FFFF);
		wr(REG_CTRL, 32'h0000_0006);
		rdm(12'h100, 32'h0000_0000, 32'hFFFF_FFFF);
		rdm(REG_CFG_DESC, 32'h0000_32E0, 32'hFFFF_FFFF);
		wr(REG_CTRL, 32'h0000_0002);
		rom(8'h2D, 16'h0002, 16'h00FF);
	endtask
	initial begin
		rst_n_in = 1'b0;
		repeat (3) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(posedge core_clk_in);
		t_defaults();
		t_read_only();
		t_power();
		t_image();
		finish_test();
	end
	// Watchdog against a hung run
	initial begin
		repeat (5000) @(posedge core_clk_in);
		hang();
	end
endmodule
bind udr_top udr_monitor u_mon (.core_clk_in, .rst_n_in, .hsel_in,
	.haddr_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out,
	.hreadyout_out, .hresp_out, .cfg_desc_out, .self_powered_out);
